/* File: src/its_pkg.sv */
// shared constants and types for the i2c slave transmit block
package its_pkg;
  localparam int LP_ADDR_W = 10;
  localparam int LP_MSB = 7;
  localparam int LP_OWN7_MSB = 6;
  localparam int LP_OWN_LO_MSB = 7;
  localparam int LP_OWN_HI_MSB = 9;
  localparam int LP_OWN_HI_LSB = 8;
  localparam int LP_HDR_MSB = 7;
  localparam int LP_HDR_LSB = 3;
  localparam int LP_HDR_AHI = 2;
  localparam int LP_HDR_ALO = 1;
  localparam int LP_RW_BIT = 0;
  localparam logic [4:0] LP_TEN_HDR = 5'h1E;
  localparam logic [3:0] LP_BYTE_BITS = 4'h8;
  localparam logic [3:0] LP_BIT_FIRST = 4'h0;
  localparam logic [3:0] LP_BIT_LAST = 4'h7;
  localparam logic [3:0] LP_CNT_STEP = 4'h1;
  localparam logic [7:0] LP_DATA_RST = 8'h00;
  localparam int LP_EVT_N = 4;
  localparam int LP_EV_HIT = 0;
  localparam int LP_EV_NACK = 1;
  localparam int LP_EV_SR = 2;
  localparam int LP_EV_USED = 3;

  typedef struct packed {
    logic enable;
    logic ten_bit;
    logic [LP_ADDR_W-1:0] own_addr;
  } its_lcfg_t;

  typedef struct packed {
    its_lcfg_t lnk;
    logic transmit_irq_enable;
  } its_cfg_t;

  typedef struct packed {
    logic hit;
    logic nack;
    logic stop;
    logic tx_empty;
    logic dir_read;
  } its_stat_t;

  localparam its_stat_t LP_STAT_RST = its_stat_t'(5'h02);

  typedef enum logic [2:0] {
    LS_IDLE, LS_ADDR, LS_ACK, LS_LOAD, LS_TX, LS_MACK, LS_IGN
  } its_lst_t;
endpackage

/* File: src/its_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module its_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule

/* File: src/its_evt_xfer.sv */
// toggle based pulse crossing between two clocks
`timescale 1ns/1ps
module its_evt_xfer (
  input wire logic i_src_clk,
  input wire logic i_dst_clk,
  input wire logic i_arst_n,
  input wire logic i_pulse,
  output logic o_pulse
);
  logic tog_reg;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge i_src_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tog_reg <= 1'b0;
    end else begin
      tog_reg <= tog_reg ^ i_pulse;
    end
  end

  // s1 feeds only s2; the edge is taken between s2 and s3
  always_ff @(posedge i_dst_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= tog_reg;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign o_pulse = s2_reg ^ s3_reg;
endmodule

/* File: src/its_slave_tx.sv */
// i2c slave transmit engine: link side on the link clock, flags on the core clock
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - 7-bit match with read bit: acknowledge, set address hit, direction read.
// - reading the status register clears the address hit flag.
// - after read match, hold scl low until the first byte is written.
// - after first bit of a byte leaves, set transmit empty.
// - writing the next byte clears transmit empty.
// - stretch scl at the msb of the next byte while data not reloaded.
// - master nack after a byte sets the nack flag.
// - software answers nack with flush; the device empties the data register.
// - stop or restart after the transfer sets the stop/restart flag.
// - reading the status register clears the stop/restart flag.
// - 10-bit first byte matching top bits with write is acknowledged.
// - second byte matching low bits: hit, direction write, acknowledge.
// - after restart, first byte match with read: hit, direction read, acknowledge.
module its_slave_tx import its_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire its_cfg_t i_cfg,
  input wire logic [7:0] i_data,
  input wire logic i_data_wr,
  input wire logic i_status_rd,
  input wire logic i_flush,
  output its_stat_t o_status,
  output logic o_irq
);
  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [1:0] pin_s;
  its_lcfg_t lcfg_s;
  logic full_s, scl_s, sda_s, scl_q_reg, sda_q_reg, scl_rise, scl_fall;
  logic bus_start, bus_stop, lnk_run, m7, hdr_ok, rw, lo_ok;
  its_lst_t st_reg, then_reg;
  logic [7:0] sh_reg, data_reg;
  logic [3:0] cnt_reg;
  logic sec_reg, armed_reg, act_reg, dir_reg, scl_oe_reg, sda_oe_reg, pin_lvl_reg;
  logic [LP_EVT_N-1:0] ev_reg, ev_core;
  logic dir_core_s, full_reg, irq_reg;
  its_stat_t stat_reg;
  // 10-bit header: fixed pattern plus the two top own-address bits
  function automatic logic hdr_match(input logic [7:0] b, input its_lcfg_t c);
    hdr_match = (b[LP_HDR_MSB:LP_HDR_LSB] == LP_TEN_HDR) &&
                (b[LP_HDR_AHI:LP_HDR_ALO] == c.own_addr[LP_OWN_HI_MSB:LP_OWN_HI_LSB]);
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // link clock domain: pins and configuration
  // pins cross inverted so the synchroniser reset reads as an idle bus, no false edge
  its_sync #(.W(2)) u_pin_sync (
    .i_clk(i_link_clk),
    .i_arst_n(i_arst_n),
    .i_d({!i_scl, !i_sda}),
    .o_q(pin_s)
  );
  // configuration is quasi-static; change it only while the bus is idle
  its_sync #(.W($bits(its_lcfg_t))) u_cfg_sync (
    .i_clk(i_link_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_cfg.lnk),
    .o_q(lcfg_s)
  );
  its_sync #(.W(1)) u_full_sync (
    .i_clk(i_link_clk),
    .i_arst_n(i_arst_n),
    .i_d(full_reg),
    .o_q(full_s)
  );
  assign scl_s = !pin_s[1];
  assign sda_s = !pin_s[0];
  assign scl_rise = scl_s && !scl_q_reg;
  assign scl_fall = !scl_s && scl_q_reg;
  assign bus_start = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign bus_stop = scl_s && scl_q_reg && !sda_q_reg && sda_s;
  assign lnk_run = lcfg_s.enable && !bus_start && !bus_stop;
  assign m7 = !lcfg_s.ten_bit &&
              (sh_reg[LP_MSB:LP_RW_BIT+1] == lcfg_s.own_addr[LP_OWN7_MSB:0]);
  assign hdr_ok = lcfg_s.ten_bit && hdr_match(sh_reg, lcfg_s);
  assign rw = sh_reg[LP_RW_BIT];
  assign lo_ok = sh_reg == lcfg_s.own_addr[LP_OWN_LO_MSB:0];

  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      pin_lvl_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
      pin_lvl_reg <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // link clock domain: protocol engine
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= LS_IDLE;
      then_reg <= LS_IDLE;
      sh_reg <= LP_DATA_RST;
      cnt_reg <= LP_BIT_FIRST;
      sec_reg <= 1'b0;
      armed_reg <= 1'b0;
      act_reg <= 1'b0;
      dir_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ev_reg <= '0;
    end else begin
      ev_reg <= '0;
      if (!lnk_run) begin
        // a stop or start always wins and frees both lines
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
        ev_reg[LP_EV_SR] <= act_reg && (bus_stop || bus_start);
        act_reg <= 1'b0;
        sec_reg <= 1'b0;
        cnt_reg <= LP_BIT_FIRST;
        if (!lcfg_s.enable || bus_stop) begin
          st_reg <= LS_IDLE;
          armed_reg <= 1'b0;
        end else begin
          st_reg <= LS_ADDR;
        end
      end else begin
        unique case (st_reg)
          LS_IDLE, LS_IGN: begin
            scl_oe_reg <= 1'b0;
          end
          LS_ADDR: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[LP_MSB-1:0], sda_s};
              cnt_reg <= cnt_reg + LP_CNT_STEP;
            end else if (scl_fall && cnt_reg == LP_BYTE_BITS) begin
              cnt_reg <= LP_BIT_FIRST;
              if (sec_reg) begin
                sec_reg <= 1'b0;
                if (lo_ok) begin
                  ev_reg[LP_EV_HIT] <= 1'b1;
                  dir_reg <= 1'b0;
                  armed_reg <= 1'b1;
                  act_reg <= 1'b1;
                  sda_oe_reg <= 1'b1;
                  then_reg <= LS_IGN;
                  st_reg <= LS_ACK;
                end else begin
                  armed_reg <= 1'b0;
                  st_reg <= LS_IGN;
                end
              end else if ((m7 || (hdr_ok && armed_reg)) && rw) begin
                ev_reg[LP_EV_HIT] <= 1'b1;
                dir_reg <= 1'b1;
                act_reg <= 1'b1;
                sda_oe_reg <= 1'b1;
                then_reg <= LS_LOAD;
                st_reg <= LS_ACK;
              end else if (hdr_ok && !rw) begin
                sda_oe_reg <= 1'b1;
                sec_reg <= 1'b1;
                then_reg <= LS_ADDR;
                st_reg <= LS_ACK;
              end else begin
                st_reg <= LS_IGN;
              end
            end
          end
          LS_ACK: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              st_reg <= then_reg;
            end
          end
          LS_LOAD: begin
            // scl is low here; keep it low until a byte is waiting
            if (full_s) begin
              sh_reg <= data_reg;
              sda_oe_reg <= !data_reg[LP_MSB];
              scl_oe_reg <= 1'b0;
              cnt_reg <= LP_BIT_FIRST;
              st_reg <= LS_TX;
            end else begin
              scl_oe_reg <= 1'b1;
            end
          end
          LS_TX: begin
            if (scl_fall) begin
              ev_reg[LP_EV_USED] <= cnt_reg == LP_BIT_FIRST;
              if (cnt_reg == LP_BIT_LAST) begin
                sda_oe_reg <= 1'b0;
                st_reg <= LS_MACK;
              end else begin
                sh_reg <= {sh_reg[LP_MSB-1:0], 1'b0};
                sda_oe_reg <= !sh_reg[LP_MSB-1];
                cnt_reg <= cnt_reg + LP_CNT_STEP;
              end
            end
          end
          LS_MACK: begin
            if (scl_rise && sda_s) begin
              ev_reg[LP_EV_NACK] <= 1'b1;
              st_reg <= LS_IGN;
            end else if (scl_fall) begin
              st_reg <= LS_LOAD;
            end
          end
          default: begin
            st_reg <= LS_IDLE;
          end
        endcase
      end
    end
  end

  assign o_scl_o = pin_lvl_reg;
  assign o_sda_o = pin_lvl_reg;
  assign o_scl_oe = scl_oe_reg;
  assign o_sda_oe = sda_oe_reg;
  //////////////////////////////////////////////////////////////////////////////
  // crossings into the core clock domain
  for (genvar gi = 0; gi < LP_EVT_N; gi++) begin : g_evt
    its_evt_xfer u_evt (
      .i_src_clk(i_link_clk),
      .i_dst_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_pulse(ev_reg[gi]),
      .o_pulse(ev_core[gi])
    );
  end

  // direction settles long before the hit pulse arrives
  its_sync #(.W(1)) u_dir_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_d(dir_reg),
    .o_q(dir_core_s)
  );
  //////////////////////////////////////////////////////////////////////////////
  // core clock domain: data register, flags, interrupt
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_reg <= LP_DATA_RST;
    end else if (i_data_wr) begin
      data_reg <= i_data;
    end else if (i_flush) begin
      data_reg <= LP_DATA_RST;
    end
  end

  // a write in the cycle the old byte is taken keeps the new byte
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      full_reg <= 1'b0;
      stat_reg <= LP_STAT_RST;
    end else begin
      stat_reg.hit <= ev_core[LP_EV_HIT] || (stat_reg.hit && !i_status_rd);
      stat_reg.nack <= ev_core[LP_EV_NACK] || (stat_reg.nack && !i_status_rd);
      stat_reg.stop <= ev_core[LP_EV_SR] || (stat_reg.stop && !i_status_rd);
      stat_reg.dir_read <= dir_core_s;
      if (i_data_wr) begin
        full_reg <= 1'b1;
        stat_reg.tx_empty <= 1'b0;
      end else if (i_flush || ev_core[LP_EV_USED]) begin
        full_reg <= 1'b0;
        stat_reg.tx_empty <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= stat_reg.hit || stat_reg.nack || stat_reg.stop ||
                 (stat_reg.tx_empty && i_cfg.transmit_irq_enable);
    end
  end

  assign o_status = stat_reg;
  assign o_irq = irq_reg;
  //////////////////////////////////////////////////////////////////////////////
  // checks
  stretch_hold_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    (st_reg == LS_LOAD && !full_s && lnk_run) |=> o_scl_oe && st_reg == LS_LOAD)
    else $error("scl not held low while no byte loaded");
  load_release_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    (st_reg == LS_LOAD && full_s && lnk_run) |=> !o_scl_oe && st_reg == LS_TX)
    else $error("scl not released after byte loaded");
  first_bit_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    (st_reg == LS_TX && scl_fall && cnt_reg == LP_BIT_FIRST && lnk_run)
    |=> ev_reg[LP_EV_USED] ##1 !ev_reg[LP_EV_USED])
    else $error("byte not marked taken after first bit");
  addr_miss_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    (st_reg == LS_ADDR && sec_reg && !lo_ok && scl_fall && cnt_reg == LP_BYTE_BITS
     && lnk_run) |=> st_reg == LS_IGN && !o_sda_oe && !ev_reg[LP_EV_HIT] && !armed_reg)
    else $error("mismatched second address byte acknowledged");
  read_hit_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    (st_reg == LS_ADDR && !sec_reg && m7 && rw && scl_fall && cnt_reg == LP_BYTE_BITS
     && lnk_run) |=> ev_reg[LP_EV_HIT] && dir_reg && o_sda_oe && st_reg == LS_ACK)
    else $error("read address match not acknowledged");
  hit_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_status_rd && !ev_core[LP_EV_HIT]) |=> !stat_reg.hit)
    else $error("address hit survived status read");
  stop_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_status_rd && !ev_core[LP_EV_SR]) |=> !stat_reg.stop)
    else $error("stop flag survived status read");
  stop_set_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ev_core[LP_EV_SR] |=> stat_reg.stop ##1 o_irq)
    else $error("stop or restart not flagged");
  nack_set_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ev_core[LP_EV_NACK] |=> stat_reg.nack ##1 o_irq)
    else $error("nack not flagged");
  empty_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_data_wr |=> !stat_reg.tx_empty && full_reg && data_reg == $past(i_data))
    else $error("write did not fill data register");
  flush_empty_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_flush && !i_data_wr) |=> stat_reg.tx_empty && !full_reg && data_reg == LP_DATA_RST)
    else $error("flush did not empty data register");
  read_hit_c: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    stat_reg.hit && stat_reg.dir_read);
  stretch_c: cover property (@(posedge i_link_clk) disable iff (!i_arst_n)
    st_reg == LS_LOAD && o_scl_oe);
  nack_c: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ev_core[LP_EV_NACK]);
  stop_c: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    stat_reg.stop && stat_reg.nack);
endmodule

/* File: test/its_master_model.sv */
// behavioural i2c bus master that reads from the slave
`timescale 1ns/1ps
module its_master_model (
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_pull,
  output logic o_sda_pull
);
  localparam int HALF = 8;
  initial begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
  end
  ////////////////////////////////////////
  task automatic wait_half();
    repeat (HALF) @(posedge i_link_clk);
  endtask
  // clock sync: a stretching slave holds the wire low, so wait for it, bounded
  task automatic rise_scl();
    int n;
    n = 0;
    o_scl_pull <= 1'b0;
    @(posedge i_link_clk);
    while (i_scl !== 1'b1 && n < 3000) begin
      @(posedge i_link_clk);
      n++;
    end
  endtask
  // sda moves two clocks after the scl fall so no false start or stop is seen
  task automatic xfer_bit(input logic b_out, output logic b_in);
    repeat (2) @(posedge i_link_clk);
    o_sda_pull <= !b_out;
    wait_half();
    rise_scl();
    b_in = i_sda;
    wait_half();
    o_scl_pull <= 1'b1;
  endtask
  task automatic start_cond();
    repeat (2) @(posedge i_link_clk);
    o_sda_pull <= 1'b0;
    wait_half();
    rise_scl();
    wait_half();
    o_sda_pull <= 1'b1;
    wait_half();
    o_scl_pull <= 1'b1;
  endtask
  task automatic stop_cond();
    repeat (2) @(posedge i_link_clk);
    o_sda_pull <= 1'b1;
    wait_half();
    rise_scl();
    wait_half();
    o_sda_pull <= 1'b0;
    wait_half();
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], x);
    end
    xfer_bit(1'b1, ack);
  endtask
  task automatic read_byte(output logic [7:0] d, input logic nack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, d[i]);
    end
    xfer_bit(nack, x);
  endtask
endmodule

/* File: test/its_slave_tx_tb.sv */
// self-checking bench for the i2c slave transmit engine
`timescale 1ns/1ps
module its_slave_tx_tb import its_pkg::*; ();
  logic core_clk, link_clk, arst_n, data_wr, status_rd, flush;
  logic irq, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, ack;
  logic [7:0] data, rd;
  its_cfg_t cfg;
  its_stat_t status;
  int err_count, checks_done;
  int cycles = 0;
  // wired-and bus with pull-ups
  wire scl_w = !(m_scl | (scl_oe & !scl_o));
  wire sda_w = !(m_sda | (sda_oe & !sda_o));
  its_slave_tx dut_u (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_link_clk(link_clk),
    .i_scl(scl_w), .i_sda(sda_w), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_cfg(cfg), .i_data(data), .i_data_wr(data_wr),
    .i_status_rd(status_rd), .i_flush(flush), .o_status(status), .o_irq(irq));
  its_master_model m_u (.i_link_clk(link_clk), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl_pull(m_scl), .o_sda_pull(m_sda));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  ////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // kind 0 data write, 1 status read, 2 flush
  task automatic sw_pulse(input int kind, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    data = d;
    data_wr = (kind == 0);
    status_rd = (kind == 1);
    flush = (kind == 2);
    @(posedge core_clk);
    #1;
    data_wr = 1'b0;
    status_rd = 1'b0;
    flush = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_empty();
    int n;
    n = 0;
    while (status.tx_empty !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic stretch_load(input logic [7:0] d);
    repeat (40) @(posedge link_clk);
    @(posedge core_clk);
    #1;
    check({scl_oe, scl_w}, 8'h02, "scl stretch");
    sw_pulse(0, d);
  endtask
  ////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    data = 8'h00;
    data_wr = 1'b0;
    status_rd = 1'b0;
    flush = 1'b0;
    cfg = '0;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge link_clk);
    #1;
    check(status, LP_STAT_RST, "reset status");
    check({scl_oe, sda_oe, irq, scl_o, sda_o}, 8'h00, "reset outs");
    arst_n = 1'b1;
    cfg = '{lnk: '{enable: 1'b1, ten_bit: 1'b0, own_addr: 10'h05A}, transmit_irq_enable: 1'b0};
    repeat (4) @(posedge link_clk);
    m_u.start_cond();
    m_u.write_byte({7'h5A, 1'b1}, ack);
    check({ack, status.hit, status.dir_read, irq}, 8'h07, "7-bit match");
    sw_pulse(1, 8'h00);
    check({status.hit, irq}, 8'h00, "hit clear");
    fork
      m_u.read_byte(rd, 1'b0);
      begin
        stretch_load(8'hA5);
        cfg.transmit_irq_enable = 1'b1;
        wait_empty();
        check({status.tx_empty, irq}, 8'h03, "empty after bit");
        sw_pulse(0, 8'h3C);
        check(status.tx_empty, 8'h00, "write fills");
      end
    join
    check(rd, 8'hA5, "byte 1");
    m_u.read_byte(rd, 1'b0);
    check(rd, 8'h3C, "byte 2");
    fork
      m_u.read_byte(rd, 1'b1);
      stretch_load(8'hC3);
    join
    check(rd, 8'hC3, "byte 3");
    check(status.nack, 8'h01, "nack flag");
    sw_pulse(0, 8'h77);
    check(status.tx_empty, 8'h00, "refill");
    cfg.transmit_irq_enable = 1'b0;
    sw_pulse(2, 8'h00);
    check(status.tx_empty, 8'h01, "flush empties");
    m_u.stop_cond();
    check(status.stop, 8'h01, "stop flag");
    sw_pulse(1, 8'h00);
    check({status.stop, status.nack, irq}, 8'h00, "flags clear");
    $display("test 7-bit read done");
    cfg = '{lnk: '{enable: 1'b1, ten_bit: 1'b1, own_addr: 10'h2A5}, transmit_irq_enable: 1'b0};
    repeat (4) @(posedge link_clk);
    m_u.start_cond();
    m_u.write_byte({LP_TEN_HDR, 2'h2, 1'b0}, ack);
    check({ack, status.hit}, 8'h00, "header ack");
    m_u.write_byte(8'hA5, ack);
    check({ack, status.hit, status.dir_read}, 8'h02, "low byte hit");
    sw_pulse(1, 8'h00);
    m_u.start_cond();
    m_u.write_byte({LP_TEN_HDR, 2'h2, 1'b1}, ack);
    check({ack, status.hit, status.dir_read}, 8'h03, "read header hit");
    sw_pulse(1, 8'h00);
    sw_pulse(0, 8'h96);
    m_u.read_byte(rd, 1'b1);
    check(rd, 8'h96, "10-bit data");
    check(status.nack, 8'h01, "10-bit nack");
    m_u.stop_cond();
    check(status.stop, 8'h01, "10-bit stop");
    sw_pulse(1, 8'h00);
    $display("test 10-bit read done");
    m_u.start_cond();
    m_u.write_byte({LP_TEN_HDR, 2'h2, 1'b0}, ack);
    check(ack, 8'h00, "header ack 2");
    m_u.write_byte(8'h5A, ack);
    check({ack, status.hit}, 8'h02, "low mismatch");
    m_u.write_byte(8'h00, ack);
    check({ack, status.hit}, 8'h02, "ignored");
    m_u.stop_cond();
    check(status.stop, 8'h00, "no stop when unaddressed");
    $display("test 10-bit mismatch done");
    finish_test();
  end
endmodule
